// ===== sifd_params.svh
// Operation
// - Each terminal has its own ON and OFF delay code, 1..10 = 0..1536 ms.
// - Rising pulses shorter than the ON delay never reach the filtered input.
// - Falling pulses shorter than the OFF delay never reach the filtered input.
// - ON and OFF suppression act together, each with its own width.
// - Dual channel pair evaluation works on the filtered inputs.
// - A detected input error is held on that terminal's errLed and safeData outputs for at least 1 s.
// - Pair mode and test pulse setting select which wiring checks run.
// - Equivalent pair with separate test pulses checks supply, ground, cross-short faults.
// - The full OFF delay adds to the input-off to data-off reaction time.
`ifndef SIFD_PARAMS_SVH
`define SIFD_PARAMS_SVH

`define SIFD_CLK_NS        10
`define SIFD_MS_NS         1000000
`define SIFD_TICK_CYC      (`SIFD_MS_NS / `SIFD_CLK_NS)

`define SIFD_NUM_TERM      8
`define SIFD_NUM_PAIR      4
`define SIFD_DLY_BASE_MS   11'h006
`define SIFD_DLY_CODE_MIN  4'h2
`define SIFD_DLY_CODE_MAX  4'ha
`define SIFD_ERR_HOLD_MS   11'h3e8
`define SIFD_DISC_MS       11'h1f4

`define SIFD_OFF_CFG       8'h00
`define SIFD_OFF_MODE      8'h20
`define SIFD_OFF_DATA      8'h24
`define SIFD_OFF_ERR       8'h28
`define SIFD_OFF_MASK      8'h2c

`define SIFD_CFG_RST       8'h11
`define SIFD_MODE_RST      16'h0000
`define SIFD_MASK_RST      8'h00

`endif

// ===== sifd_pkg.sv
package sifd_pkg;

  typedef enum logic [1:0]
  {
    SIFD_SINGLE = 2'h0,
    SIFD_EQUIV  = 2'h1,
    SIFD_COMPL  = 2'h2,
    SIFD_MODE_X = 2'h3
  } sifd_mode_e;

  typedef enum logic [1:0]
  {
    SIFD_TP_NONE = 2'h0,
    SIFD_TP_SAME = 2'h1,
    SIFD_TP_DIFF = 2'h2,
    SIFD_TP_X    = 2'h3
  } sifd_test_e;

  typedef struct packed
  {
    logic [3:0] offCode;
    logic [3:0] onCode;
  } sifd_cfg_s;

  typedef struct packed
  {
    sifd_test_e test;
    sifd_mode_e mode;
  } sifd_pair_s;

endpackage

// ===== sifd_delay_filter.sv
`timescale 1ns/100ps
`include "sifd_params.svh"

module sifd_delay_filter
(
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic           msTick,
  input  wire logic           rawIn,
  input  sifd_pkg::sifd_cfg_s cfg,
  output logic                filtOut
);

  logic [10:0] cnt_reg;
  logic [10:0] cnt_next;
  logic        filt_reg;
  logic        filt_next;
  logic [10:0] dlyMs;

  function automatic logic [10:0] codeMs(input logic [3:0] code);
    logic [3:0] sh;
    sh = code - `SIFD_DLY_CODE_MIN;
    if (code < `SIFD_DLY_CODE_MIN || code > `SIFD_DLY_CODE_MAX)
      codeMs = 11'h000;
    else
      codeMs = 11'(`SIFD_DLY_BASE_MS << sh);
  endfunction

  always_comb
  begin
    dlyMs     = rawIn ? codeMs(cfg.onCode) : codeMs(cfg.offCode);
    cnt_next  = cnt_reg;
    filt_next = filt_reg;
    if (rawIn == filt_reg)
      cnt_next = 11'h000;
    else if (dlyMs == 11'h000)
    begin
      filt_next = rawIn;
      cnt_next  = 11'h000;
    end
    else if (msTick)
    begin
      // One extra tick, since the first may arrive at once
      if (cnt_reg + 11'h001 > dlyMs)
      begin
        filt_next = rawIn;
        cnt_next  = 11'h000;
      end
      else
        cnt_next = cnt_reg + 11'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_reg  <= 11'h000;
      filt_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      filt_reg <= filt_next;
    end
  end

  assign filtOut = filt_reg;

  a_pass_through: assert property (@(posedge clk) disable iff (!rst_b)
    (rawIn != filt_reg && dlyMs == 11'h000) |=> filt_reg == $past(rawIn))
    else $error("Zero delay did not pass input through");

  a_on_wait: assert property (@(posedge clk) disable iff (!rst_b)
    (!filt_reg && rawIn && dlyMs != 11'h000 && cnt_reg + 11'h001 <= dlyMs)
    |=> !filt_reg)
    else $error("Filtered input rose before ON delay");

  a_off_wait: assert property (@(posedge clk) disable iff (!rst_b)
    (filt_reg && !rawIn && dlyMs != 11'h000 && cnt_reg + 11'h001 <= dlyMs)
    |=> filt_reg)
    else $error("Filtered input fell before OFF delay");

endmodule

// ===== sifd_top.sv
`timescale 1ns/100ps
`include "sifd_params.svh"

module sifd_top
#(
  parameter int unsigned TICK_CYC = `SIFD_TICK_CYC
)
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  rawIn,
  input  wire logic [7:0]  testFail,
  input  wire logic [3:0]  crossShort,
  output logic      [7:0]  safeData,
  output logic      [7:0]  errLed,
  output logic             irq
);

  localparam int NT = `SIFD_NUM_TERM;
  localparam int NP = `SIFD_NUM_PAIR;

  // Millisecond time base
  logic [16:0] tick_reg;
  logic [16:0] tick_next;
  logic        msTick_reg;
  logic        msTick_next;

  always_comb
  begin
    msTick_next = 1'b0;
    tick_next   = tick_reg + 17'h00001;
    if (tick_reg >= 17'(TICK_CYC - 1))
    begin
      tick_next   = 17'h00000;
      msTick_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_reg   <= 17'h00000;
      msTick_reg <= 1'b0;
    end
    else
    begin
      tick_reg   <= tick_next;
      msTick_reg <= msTick_next;
    end
  end

  // Configuration and interrupt registers
  sifd_pkg::sifd_cfg_s  [NT-1:0] cfg_reg;
  sifd_pkg::sifd_cfg_s  [NT-1:0] cfg_next;
  sifd_pkg::sifd_pair_s [NP-1:0] mode_reg;
  sifd_pkg::sifd_pair_s [NP-1:0] mode_next;
  logic [7:0]  err_reg;
  logic [7:0]  err_next;
  logic [7:0]  mask_reg;
  logic [7:0]  mask_next;
  logic [31:0] prdata_next;
  logic        pready_next;
  logic        pslverr_next;
  logic        irq_next;
  logic        mapped;
  logic        wrEn;
  logic [7:0]  errCause;

  always_comb
  begin
    mapped      = 1'b1;
    prdata_next = 32'h00000000;
    if (paddr[1:0] != 2'h0)
      mapped = 1'b0;
    else if (paddr < `SIFD_OFF_MODE)
      prdata_next = {24'h000000, cfg_reg[paddr[4:2]]};
    else if (paddr == `SIFD_OFF_MODE)
      prdata_next = {16'h0000, mode_reg};
    else if (paddr == `SIFD_OFF_DATA)
      prdata_next = {16'h0000, errLed, safeData};
    else if (paddr == `SIFD_OFF_ERR)
      prdata_next = {24'h000000, err_reg};
    else if (paddr == `SIFD_OFF_MASK)
      prdata_next = {24'h000000, mask_reg};
    else
      mapped = 1'b0;
    if (!(psel && !penable))
      prdata_next = prdata;
    pready_next  = psel && !penable;
    pslverr_next = psel && !penable && !mapped;
    wrEn         = psel && penable && pready && pwrite && !pslverr;
    cfg_next     = cfg_reg;
    mode_next    = mode_reg;
    mask_next    = mask_reg;
    err_next     = err_reg;
    if (wrEn && paddr < `SIFD_OFF_MODE)
      cfg_next[paddr[4:2]] = pwdata[7:0];
    if (wrEn && paddr == `SIFD_OFF_MODE)
      mode_next = pwdata[15:0];
    if (wrEn && paddr == `SIFD_OFF_MASK)
      mask_next = pwdata[7:0];
    if (wrEn && paddr == `SIFD_OFF_ERR)
      err_next = err_reg & ~pwdata[7:0];
    err_next = err_next | errCause;
    irq_next = |(err_next & mask_next);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_reg  <= {NT{`SIFD_CFG_RST}};
      mode_reg <= `SIFD_MODE_RST;
      mask_reg <= `SIFD_MASK_RST;
      err_reg  <= 8'h00;
      prdata   <= 32'h00000000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      irq      <= 1'b0;
    end
    else
    begin
      cfg_reg  <= cfg_next;
      mode_reg <= mode_next;
      mask_reg <= mask_next;
      err_reg  <= err_next;
      prdata   <= prdata_next;
      pready   <= pready_next;
      pslverr  <= pslverr_next;
      irq      <= irq_next;
    end
  end

  // Per-terminal delay filters
  logic [7:0] filt;

  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++)
    begin : g_filt
      sifd_delay_filter u_filt
      (
        .clk     (clk),
        .rst_b   (rst_b),
        .msTick  (msTick_reg),
        .rawIn   (rawIn[gi]),
        .cfg     (cfg_reg[gi]),
        .filtOut (filt[gi])
      );
    end
  endgenerate

  // Pair evaluation on filtered inputs
  logic [10:0] disc_reg  [NP];
  logic [10:0] disc_next [NP];
  logic [3:0]  pairBad;
  logic [3:0]  discErr;
  logic [3:0]  pairErr;
  logic [3:0]  pairOn;
  logic [3:0]  isDual;

  generate
    for (gi = 0; gi < NP; gi++)
    begin : g_pair
      always_comb
      begin
        isDual[gi]  = mode_reg[gi].mode == sifd_pkg::SIFD_EQUIV ||
                      mode_reg[gi].mode == sifd_pkg::SIFD_COMPL;
        pairBad[gi] = 1'b0;
        pairOn[gi]  = 1'b0;
        case (mode_reg[gi].mode)
          sifd_pkg::SIFD_EQUIV:
          begin
            pairBad[gi] = filt[2*gi] != filt[2*gi+1];
            pairOn[gi]  = filt[2*gi] && filt[2*gi+1];
          end
          sifd_pkg::SIFD_COMPL:
          begin
            pairBad[gi] = filt[2*gi] == filt[2*gi+1];
            pairOn[gi]  = filt[2*gi] && !filt[2*gi+1];
          end
          default:
          begin
            pairBad[gi] = 1'b0;
            pairOn[gi]  = 1'b0;
          end
        endcase
        disc_next[gi] = disc_reg[gi];
        if (!pairBad[gi])
          disc_next[gi] = 11'h000;
        else if (msTick_reg && disc_reg[gi] < `SIFD_DISC_MS)
          disc_next[gi] = disc_reg[gi] + 11'h001;
        discErr[gi] = disc_reg[gi] == `SIFD_DISC_MS;
        // Cross-shorts only seen with separate test sources
        pairErr[gi] = discErr[gi] || (crossShort[gi] &&
                      mode_reg[gi].mode == sifd_pkg::SIFD_EQUIV &&
                      mode_reg[gi].test == sifd_pkg::SIFD_TP_DIFF);
      end

      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          disc_reg[gi] <= 11'h000;
        else
          disc_reg[gi] <= disc_next[gi];
      end
    end
  endgenerate

  // Error hold and safety data per terminal
  logic [10:0] hold_reg  [NT];
  logic [10:0] hold_next [NT];
  logic [7:0]  errAct;
  logic [7:0]  safe_next;

  generate
    for (gi = 0; gi < NT; gi++)
    begin : g_term
      always_comb
      begin
        // Test pulse readback errors need pulses enabled
        errCause[gi] = (testFail[gi] &&
                        mode_reg[gi/2].test != sifd_pkg::SIFD_TP_NONE) ||
                       (isDual[gi/2] && pairErr[gi/2]);
        hold_next[gi] = hold_reg[gi];
        if (errCause[gi])
          hold_next[gi] = `SIFD_ERR_HOLD_MS + 11'h001;
        else if (msTick_reg && hold_reg[gi] != 11'h000)
          hold_next[gi] = hold_reg[gi] - 11'h001;
        errAct[gi] = errCause[gi] || hold_reg[gi] != 11'h000;
        if (!isDual[gi/2])
          safe_next[gi] = filt[gi] && !errAct[gi];
        else if (gi % 2 == 1)
          safe_next[gi] = 1'b0;
        else
          safe_next[gi] = pairOn[gi/2] && !errAct[gi] &&
                          !errAct[gi|1];
      end

      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          hold_reg[gi] <= 11'h000;
          safeData[gi] <= 1'b0;
          errLed[gi]   <= 1'b0;
        end
        else
        begin
          hold_reg[gi] <= hold_next[gi];
          safeData[gi] <= safe_next[gi];
          errLed[gi]   <= errAct[gi];
        end
      end

      a_err_load: assert property (@(posedge clk) disable iff (!rst_b)
        errCause[gi] |=> hold_reg[gi] == `SIFD_ERR_HOLD_MS + 11'h001 &&
                         errLed[gi])
        else $error("Error hold not loaded");

      a_err_release: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(errLed[gi]) |-> $past(hold_reg[gi]) <= 11'h001)
        else $error("Error indication dropped early");

      a_safe_gated: assert property (@(posedge clk) disable iff (!rst_b)
        errAct[gi] |=> !safeData[gi])
        else $error("Safety data on during held error");
    end
  endgenerate

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access;
    psel && penable && pready;
  endsequence

  a_apb_ready: assert property (@(posedge clk) disable iff (!rst_b)
    s_setup |=> s_access or !penable)
    else $error("Slave did not answer next cycle");

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 irq == |(err_reg & mask_reg))
    else $error("Interrupt level does not match status");

  a_sticky_set: assert property (@(posedge clk) disable iff (!rst_b)
    errCause != 8'h00 |=> (err_reg & $past(errCause)) == $past(errCause))
    else $error("Error event lost from status");

  a_dual_odd: assert property (@(posedge clk) disable iff (!rst_b)
    isDual[0] && $past(isDual[0]) |-> !safeData[1])
    else $error("Odd terminal of dual pair is active");

  a_disc_flag: assert property (@(posedge clk) disable iff (!rst_b)
    !pairBad[0] |=> disc_reg[0] == 11'h000)
    else $error("Discrepancy timer not restarted");

endmodule

// ===== sifd_switch_model.sv
`timescale 1ns/100ps

module sifd_switch_model
(
  input  wire logic       clk,
  input  wire logic [7:0] target,
  input  wire logic [7:0] stuck,
  input  wire logic [3:0] pairShort,
  output logic      [7:0] rawIn,
  output logic      [7:0] testFail,
  output logic      [3:0] crossShort
);
  // Stuck contact reads ON and fails its test pulse
  always_ff @(posedge clk)
  begin
    rawIn      <= target | stuck;
    testFail   <= stuck;
    crossShort <= pairShort;
  end
endmodule

// ===== safety_input_filter_diag_tb.sv
`timescale 1ns/100ps
`include "sifd_params.svh"

module safety_input_filter_diag_tb;
  localparam int T = 10;
  logic        clk       = 1'b0;
  logic        rst_b     = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic [7:0]  target    = 8'h00;
  logic [7:0]  stuck     = 8'h00;
  logic [3:0]  pairShort = 4'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq, err;
  logic [7:0]  rawIn, testFail, safeData, errLed;
  logic [3:0]  crossShort;
  int          fails = 0, n_tests = 0, seed = 32'hc0ec, n, c, v;

  always #5 clk = ~clk;

  sifd_top #(.TICK_CYC(T)) i_sifd_top
  (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rawIn(rawIn),
    .testFail(testFail), .crossShort(crossShort), .safeData(safeData),
    .errLed(errLed), .irq(irq)
  );

  sifd_switch_model i_sifd_switch_model
  (
    .clk(clk), .target(target), .stuck(stuck), .pairShort(pairShort),
    .rawIn(rawIn), .testFail(testFail), .crossShort(crossShort)
  );

  function automatic int dly(input int code);
    return (code == 1) ? 0 : 6 << (code - 2);
  endfunction

  task automatic end_sim();
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic bad_wait();
    fails++;
    $display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    end_sim();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
      bad_wait();
  endtask

  // Waits for safeData (led=0) or errLed (led=1) bit i to reach b
  task automatic wait_bit(input logic led, input int i, input logic b,
                          input int lim);
    for (n = 0; n < lim; n++)
    begin
      @(posedge clk);
      if ((led ? errLed[i] : safeData[i]) === b)
        break;
    end
    if (n >= lim)
      bad_wait();
  endtask

  task automatic steady(input int i, input logic b, input int cyc);
    logic bad;
    bad = 1'b0;
    repeat (cyc)
    begin
      @(posedge clk);
      if (safeData[i] !== b)
        bad = 1'b1;
    end
    chk({31'h0, bad}, 32'h0);
  endtask

  task automatic pulse(input int i, input int wdt);
    @(posedge clk);
    target[i] <= ~target[i];
    repeat (wdt) @(posedge clk);
    target[i] <= ~target[i];
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, 8'h1c, 32'h0);
    chk(rd, {24'h0, `SIFD_CFG_RST});
    apb(1'b0, `SIFD_OFF_MODE, 32'h0);
    chk(rd, {16'h0, `SIFD_MODE_RST});
    apb(1'b0, `SIFD_OFF_MASK, 32'h0);
    chk(rd, {24'h0, `SIFD_MASK_RST});
    apb(1'b1, 8'h21, 32'h0941);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h30, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b0, `SIFD_OFF_MODE, 32'h0);
    chk(rd, 32'h0);
    for (c = 1; c <= 10; c++)
    begin
      apb(1'b1, 8'h1c, 32'h10 | c);
      @(posedge clk);
      target[7] <= 1'b1;
      wait_bit(1'b0, 7, 1'b1, dly(c) * T + 20);
      chk_rng(n, dly(c) * T, dly(c) * T + T + 5);
      @(posedge clk);
      target[7] <= 1'b0;
      wait_bit(1'b0, 7, 1'b0, 10);
    end
    apb(1'b1, 8'h18, 32'h33);
    for (v = 0; v < 2; v++)
    begin
      repeat (5)
      begin
        pulse(6, 1 + $unsigned($random(seed)) % 119);
        steady(6, v[0], 1 + $unsigned($random(seed)) % 20);
      end
      steady(6, v[0], 130);
      @(posedge clk);
      target[6] <= ~v[0];
      wait_bit(1'b0, 6, ~v[0], 200);
      chk_rng(n, 120, 135);
    end
    apb(1'b1, 8'h00, 32'h12);
    apb(1'b1, `SIFD_OFF_MODE, 32'h0941);
    @(posedge clk);
    target[1:0] <= 2'b11;
    wait_bit(1'b0, 0, 1'b1, 100);
    chk_rng(n, 60, 75);
    chk({30'h0, safeData[1:0]}, 32'h1);
    @(posedge clk);
    target[1] <= 1'b0;
    wait_bit(1'b1, 0, 1'b1, 5100);
    chk_rng(n, 4980, 5020);
    target[0] <= 1'b0;
    wait_bit(1'b1, 0, 1'b0, 10100);
    chk_rng(n, 9990, 10060);
    apb(1'b0, `SIFD_OFF_ERR, 32'h0);
    chk(rd, 32'h3);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `SIFD_OFF_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `SIFD_OFF_ERR, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, `SIFD_OFF_ERR, 32'h0);
    chk(rd, 32'h2);
    // Complementary pair on terminals 2 and 3
    target[2] <= 1'b1;
    apb(1'b1, `SIFD_OFF_MODE, 32'h0921);
    apb(1'b0, `SIFD_OFF_DATA, 32'h0);
    chk(rd, 32'h4);
    target[3] <= 1'b1;
    wait_bit(1'b0, 2, 1'b0, 10);
    chk_rng(n, 2, 4);
    target[3] <= 1'b0;
    wait_bit(1'b0, 2, 1'b1, 10);
    chk_rng(n, 2, 4);
    apb(1'b1, `SIFD_OFF_MODE, 32'h0941);
    target[2] <= 1'b0;
    stuck[6]     <= 1'b1;
    pairShort[3] <= 1'b1;
    repeat (20) @(posedge clk);
    chk({24'h0, errLed}, 32'h0);
    stuck[2]     <= 1'b1;
    pairShort[2] <= 1'b1;
    repeat (20) @(posedge clk);
    chk({24'h0, errLed}, 32'h34);
    end_sim();
  end
endmodule
